/* File: hw/sfe_cmd_engine.sv */
// Serial flash command engine: link decoder, array, self-timed ops, APB registers
//
// Summary of operation
// RULE_01: Opcode 03h plus 24-bit address streams data.
// RULE_02: Read address increments, wraps top to zero.
// RULE_03: Opcode 0Bh adds one dummy byte first.
// RULE_04: Host holds select low; rise ends stream.
// RULE_05: Opcode 02h, address, one byte MSB first.
// RULE_06: Program or erase starts only at select rise.
// RULE_07: Writes need a prior write unlock command.
// RULE_08: Writes aimed at protected blocks are ignored.
// RULE_09: Chip erase ignored if anything is protected.
// RULE_10: Host programs only bytes already erased.
// RULE_11: Self-timed operations hold the busy flag.
// RULE_12: Opcode ADh programs an even/odd byte pair.
// RULE_13: Later pairs go to next two addresses.
// RULE_14: Pair mode accepts pair, status, lock only.
// RULE_15: Host ends pair mode with write lock.
// RULE_16: Pair mode stops at top, clears both flags.
// RULE_17: Opcode 70h enables busy level on output.
// RULE_18: Busy level drives output while select low; the code drives it only in pair mode.
// RULE_19: Opcode 80h returns output to status bytes.
// RULE_20: Opcode D8h erases the addressed 64K block.
// RULE_21: Opcode 20h erases the addressed 4K sector.
// RULE_22: Opcode 60h or C7h erases whole array.
// RULE_23: Status read anytime, repeats until select rises.
// RULE_24: Write unlock sets the write latch flag.
// RULE_25: Write lock clears latch and pair flags.
// RULE_26: Sample input on rise, shift output on fall.
`timescale 1ns/1ps

module sfe_cmd_engine
#(
	parameter int unsigned SECTOR_ERASE_CYC = sfe_pkg::SECTOR_ERASE_CYC,
	parameter int unsigned BLOCK_ERASE_CYC  = sfe_pkg::BLOCK_ERASE_CYC,
	parameter int unsigned CHIP_ERASE_CYC   = sfe_pkg::CHIP_ERASE_CYC
)
(
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [sfe_pkg::PADDR_W-1:0]  paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         link_sel_n,
	input  wire logic                         link_clk,
	input  wire logic                         link_din,
	output logic                              link_dout,
	output logic                              link_dout_oe_n
);
	import sfe_pkg::*;

	localparam int AW = ADDR_W;

	// ****************************************************************
	// Storage and state
	// ****************************************************************
	logic [7:0]       mem [0:(1<<AW)-1];
	logic [2:0]       sel_sync_q;
	logic [2:0]       clk_sync_q;
	logic [1:0]       din_sync_q;
	sfe_phase_t       phase_q;
	logic [2:0]       bit_cnt_q;
	logic [7:0]       rx_sh_q;
	logic [7:0]       cmd_q;
	logic [1:0]       acnt_q;
	logic             dcnt_q;
	logic [23:0]      addr_q;
	logic [7:0]       d0_q;
	logic [7:0]       d1_q;
	logic             ready_q;
	logic [7:0]       tx_q;
	logic [2:0]       ocnt_q;
	logic [AW-1:0]    rptr_q;
	logic             dout_q;
	logic             dout_oe_n_q;
	logic             wlf_q;
	logic             inc_q;
	logic             hwb_q;
	logic [31:0]      timer_q;
	logic             walk_q;
	logic [AW-1:0]    wptr_q;
	logic [AW-1:0]    wend_q;
	logic [AW-1:0]    aptr_q;
	logic             op_inc_q;
	logic             busy_q;
	logic [NBLK-1:0]  prot_q;
	logic [31:0]      prdata_q;
	logic             pready_q;
	logic             pslverr_q;

	// ****************************************************************
	// Link edge detection
	// ****************************************************************
	wire sel_low  = ~sel_sync_q[1];
	wire sel_fall = sel_sync_q[2] & ~sel_sync_q[1];
	wire sel_rise = ~sel_sync_q[2] & sel_sync_q[1];
	wire clk_rise = sel_low & ~clk_sync_q[2] & clk_sync_q[1];
	wire clk_fall = sel_low & clk_sync_q[2] & ~clk_sync_q[1];
	wire din      = din_sync_q[1];

	// ****************************************************************
	// Receive decode
	// ****************************************************************
	wire [7:0]  rx_byte   = {rx_sh_q[6:0], din};
	wire        byte_done = clk_rise & (bit_cnt_q == LAST_BIT);
	wire [23:0] addr_next = {addr_q[15:0], rx_byte};
	wire        busy_w    = (timer_q != 32'h0) | walk_q;

	wire r_read   = rx_byte == OP_READ;
	wire r_fast   = rx_byte == OP_FAST_READ;
	wire r_status = rx_byte == OP_STATUS_READ;
	wire r_lock   = rx_byte == OP_WRITE_LOCK;
	wire r_inc    = rx_byte == OP_INC_PROG;
	wire r_addr   = r_read | r_fast | (rx_byte == OP_BYTE_PROG) | (rx_byte == OP_BLOCK_ERASE)
		| (rx_byte == OP_SECTOR_ERASE) | (r_inc & ~inc_q);
	wire r_single = (rx_byte == OP_WRITE_UNLOCK) | r_lock | (rx_byte == OP_HW_BUSY_ON)
		| (rx_byte == OP_HW_BUSY_OFF) | (rx_byte == OP_CHIP_ERASE_A)
		| (rx_byte == OP_CHIP_ERASE_B);
	// While busy only status passes; inside pair mode only three commands do
	wire r_allowed = busy_w ? r_status : (inc_q ? (r_inc | r_status | r_lock) : 1'b1); // RULE_14

	wire x_prog   = cmd_q == OP_BYTE_PROG;
	wire x_inc    = cmd_q == OP_INC_PROG;
	wire x_be     = cmd_q == OP_BLOCK_ERASE;
	wire x_se     = cmd_q == OP_SECTOR_ERASE;
	wire x_chip   = (cmd_q == OP_CHIP_ERASE_A) | (cmd_q == OP_CHIP_ERASE_B);

	// ****************************************************************
	// Read data path
	// ****************************************************************
	wire [AW-1:0] rd_addr = (phase_q == PH_ADDR) ? addr_next[AW-1:0]
		: ((phase_q == PH_DUMMY) ? addr_q[AW-1:0] : rptr_q);
	wire [7:0]    rd_byte = mem[rd_addr];
	wire [AW-1:0] rd_inc  = rd_addr + AW'(1); // RULE_02
	wire [7:0]    status_byte = (8'(busy_w) << ST_BUSY_BIT) | (8'(wlf_q) << ST_WLF_BIT)
		| (8'(hwb_q) << ST_HWB_BIT) | (8'(inc_q) << ST_INC_BIT);
	wire load_rd = byte_done & (((phase_q == PH_ADDR) & (acnt_q == ADDR_LAST_BYTE)
		& (cmd_q == OP_READ)) | (phase_q == PH_DUMMY));
	wire load_st = byte_done & (phase_q == PH_CMD) & r_allowed & r_status;
	wire streaming = (phase_q == PH_RDOUT) | (phase_q == PH_STOUT);
	wire hwb_drive = sel_low & hwb_q & inc_q & ~streaming;

	// ****************************************************************
	// Write path decode
	// ****************************************************************
	wire          exec     = sel_rise & ready_q & (bit_cnt_q == 3'h0); // RULE_06
	wire [AW-1:0] tgt_inc  = inc_q ? aptr_q : {addr_q[AW-1:1], 1'b0}; // RULE_12
	wire [AW-1:0] tgt      = x_inc ? tgt_inc : addr_q[AW-1:0];
	wire          tgt_prot = prot_q[tgt[AW-1:BLOCK_LSB]];
	wire          go_prog  = exec & x_prog & wlf_q & ~tgt_prot; // RULE_07 RULE_08
	wire          go_inc   = exec & x_inc & wlf_q & ~tgt_prot; // RULE_08
	wire          go_erase = exec & wlf_q & (((x_be | x_se) & ~tgt_prot)
		| (x_chip & (prot_q == PROT_RST))); // RULE_09
	wire [AW-1:0] er_mask  = x_chip ? {AW{1'b1}}
		: (x_be ? {{(AW-BLOCK_LSB){1'b0}}, {BLOCK_LSB{1'b1}}}
		: {{(AW-SECTOR_LSB){1'b0}}, {SECTOR_LSB{1'b1}}}); // RULE_20 RULE_21 RULE_22
	wire [31:0]   er_cyc   = x_chip ? CHIP_ERASE_CYC : (x_be ? BLOCK_ERASE_CYC : SECTOR_ERASE_CYC);
	wire          op_done  = busy_q & ~busy_w;
	wire [AW-1:0] aptr_nxt = aptr_q + AW'(2); // RULE_13
	wire          inc_last = (&aptr_q[AW-1:1]) | prot_q[aptr_nxt[AW-1:BLOCK_LSB]];

	// ****************************************************************
	// Synchronisers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sel_sync_q <= 3'h7;
			clk_sync_q <= 3'h0;
			din_sync_q <= 2'h0;
		end
		else
		begin
			sel_sync_q <= {sel_sync_q[1:0], link_sel_n};
			clk_sync_q <= {clk_sync_q[1:0], link_clk};
			din_sync_q <= {din_sync_q[0], link_din};
		end
	end

	// ****************************************************************
	// Command framing
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_q   <= PH_SKIP;
			bit_cnt_q <= 3'h0;
			rx_sh_q   <= 8'h00;
			cmd_q     <= 8'h00;
			acnt_q    <= 2'h0;
			dcnt_q    <= 1'b0;
			addr_q    <= 24'h000000;
			d0_q      <= 8'h00;
			d1_q      <= 8'h00;
			ready_q   <= 1'b0;
		end
		else if (sel_fall)
		begin
			phase_q   <= PH_CMD;
			bit_cnt_q <= 3'h0;
			acnt_q    <= 2'h0;
			dcnt_q    <= 1'b0;
			ready_q   <= 1'b0;
		end
		else if (sel_rise)
		begin
			phase_q <= PH_SKIP;
			ready_q <= 1'b0;
		end
		else if (clk_rise)
		begin
			rx_sh_q   <= rx_byte; // RULE_26
			bit_cnt_q <= bit_cnt_q + 3'h1;
			if (byte_done)
			begin
				unique case (phase_q)
					PH_CMD:
					begin
						cmd_q <= rx_byte;
						if (!r_allowed)
							phase_q <= PH_SKIP;
						else if (r_status)
							phase_q <= PH_STOUT; // RULE_23
						else if (r_addr)
							phase_q <= PH_ADDR; // RULE_01 RULE_03
						else if (r_inc)
							phase_q <= PH_WDATA; // RULE_13
						else
						begin
							ready_q <= r_single;
							phase_q <= PH_SKIP;
						end
					end
					PH_ADDR:
					begin
						addr_q <= addr_next;
						acnt_q <= acnt_q + 2'h1;
						if (acnt_q == ADDR_LAST_BYTE)
						begin
							if (cmd_q == OP_READ)
								phase_q <= PH_RDOUT; // RULE_01
							else if (cmd_q == OP_FAST_READ)
								phase_q <= PH_DUMMY; // RULE_03
							else if (x_prog | x_inc)
								phase_q <= PH_WDATA;
							else
							begin
								ready_q <= 1'b1;
								phase_q <= PH_SKIP;
							end
						end
					end
					PH_DUMMY:
						phase_q <= PH_RDOUT; // RULE_03
					PH_WDATA:
					begin
						dcnt_q <= 1'b1;
						if (!dcnt_q)
							d0_q <= rx_byte; // RULE_05
						else
							d1_q <= rx_byte;
						if (x_prog | dcnt_q)
						begin
							ready_q <= 1'b1;
							phase_q <= PH_SKIP;
						end
					end
					PH_RDOUT, PH_STOUT, PH_SKIP:
					begin
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// Output shifter
	// ****************************************************************
	// A read turns the output on only at its first falling edge, so a read never
	// drives the wire while the host may still be sending address bits.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_q        <= 8'h00;
			ocnt_q      <= 3'h0;
			rptr_q      <= '0;
			dout_q      <= 1'b0;
			dout_oe_n_q <= 1'b1;
		end
		else if (!sel_low)
			dout_oe_n_q <= 1'b1; // RULE_04 RULE_18
		else if (load_rd | load_st)
		begin
			tx_q   <= load_rd ? rd_byte : status_byte;
			ocnt_q <= 3'h0;
			if (load_rd)
				rptr_q <= rd_inc;
		end
		else if (clk_fall & streaming)
		begin
			dout_q      <= tx_q[7]; // RULE_26
			dout_oe_n_q <= 1'b0;
			ocnt_q      <= ocnt_q + 3'h1;
			if (ocnt_q == LAST_BIT)
			begin
				tx_q <= (phase_q == PH_RDOUT) ? rd_byte : status_byte; // RULE_23
				if (phase_q == PH_RDOUT)
					rptr_q <= rd_inc; // RULE_02
			end
			else
				tx_q <= {tx_q[6:0], 1'b0};
		end
		else if (hwb_drive)
		begin
			dout_q      <= ~busy_w; // RULE_18
			dout_oe_n_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Write latch, pair mode and self-timed operations
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wlf_q    <= 1'b0;
			inc_q    <= 1'b0;
			hwb_q    <= 1'b0;
			timer_q  <= 32'h0;
			walk_q   <= 1'b0;
			wptr_q   <= '0;
			wend_q   <= '0;
			aptr_q   <= '0;
			op_inc_q <= 1'b0;
			busy_q   <= 1'b0;
		end
		else
		begin
			busy_q <= busy_w; // RULE_11
			if (timer_q != 32'h0)
				timer_q <= timer_q - 32'h1;
			if (walk_q)
			begin
				wptr_q <= wptr_q + AW'(1);
				if (wptr_q == wend_q)
					walk_q <= 1'b0;
			end
			if (op_done)
			begin
				if (!op_inc_q)
					wlf_q <= 1'b0;
				else if (inc_last)
				begin
					inc_q <= 1'b0; // RULE_16
					wlf_q <= 1'b0;
				end
				else
					aptr_q <= aptr_nxt; // RULE_13
			end
			if (exec)
			begin
				if (cmd_q == OP_WRITE_UNLOCK)
					wlf_q <= 1'b1; // RULE_24
				if (cmd_q == OP_WRITE_LOCK)
				begin
					wlf_q <= 1'b0; // RULE_25
					inc_q <= 1'b0;
				end
				if (cmd_q == OP_HW_BUSY_ON)
					hwb_q <= 1'b1; // RULE_17
				if (cmd_q == OP_HW_BUSY_OFF)
					hwb_q <= 1'b0; // RULE_19
			end
			if (go_prog | go_inc)
			begin
				timer_q  <= 32'(BYTE_PROGRAM_CYC); // RULE_11
				op_inc_q <= go_inc;
			end
			if (go_inc)
			begin
				inc_q  <= 1'b1; // RULE_12
				aptr_q <= tgt;
			end
			if (go_erase)
			begin
				walk_q   <= 1'b1;
				wptr_q   <= addr_q[AW-1:0] & ~er_mask;
				wend_q   <= addr_q[AW-1:0] | er_mask;
				timer_q  <= er_cyc;
				op_inc_q <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Array writes
	// ****************************************************************
	// Erase walks one byte a cycle under the busy timer, so a shortened
	// erase time still waits for the walk to finish.
	always_ff @(posedge pclk)
	begin
		if (walk_q)
			mem[wptr_q] <= ERASED_BYTE; // RULE_20 RULE_21 RULE_22
		if (go_prog | go_inc)
			mem[tgt] <= mem[tgt] & d0_q; // RULE_05
		if (go_inc)
			mem[{tgt[AW-1:1], 1'b1}] <= mem[{tgt[AW-1:1], 1'b1}] & d1_q; // RULE_12
	end

	// ****************************************************************
	// APB slave
	// ****************************************************************
	wire        apb_setup = psel & ~penable;
	wire        apb_wr    = psel & penable & pwrite & pready_q;
	wire        hit_prot  = paddr == REG_PROT_OFS;
	wire        hit_stat  = paddr == REG_STATUS_OFS;
	wire [31:0] apb_rdata = hit_prot ? 32'(prot_q) : (hit_stat ? 32'(status_byte) : 32'h0);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prot_q    <= PROT_RST;
			prdata_q  <= 32'h0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q  <= apb_setup;
			pslverr_q <= apb_setup & ~(hit_prot | hit_stat);
			if (apb_setup)
				prdata_q <= pwrite ? 32'h0 : apb_rdata;
			if (apb_wr & hit_prot)
				prot_q <= pwdata[NBLK-1:0]; // RULE_08
		end
	end

	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign link_dout      = dout_q;
	assign link_dout_oe_n = dout_oe_n_q;

endmodule // sfe_cmd_engine

/* File: inc/sfe_pkg.sv */
// Constants, opcodes, register map and types of the serial flash command engine
package sfe_pkg;

	// ****************************************************************
	// Array geometry
	// ****************************************************************
	localparam int ADDR_W     = 19;
	localparam int BLOCK_LSB  = 16;
	localparam int SECTOR_LSB = 12;
	localparam int NBLK       = 1 << (ADDR_W - BLOCK_LSB);
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// ****************************************************************
	// Link opcodes
	// ****************************************************************
	localparam logic [7:0] OP_READ         = 8'h03;
	localparam logic [7:0] OP_FAST_READ    = 8'h0b;
	localparam logic [7:0] OP_BYTE_PROG    = 8'h02;
	localparam logic [7:0] OP_INC_PROG     = 8'had;
	localparam logic [7:0] OP_BLOCK_ERASE  = 8'hd8;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
	localparam logic [7:0] OP_STATUS_READ  = 8'h05;
	localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
	localparam logic [7:0] OP_WRITE_LOCK   = 8'h04;
	localparam logic [7:0] OP_HW_BUSY_ON   = 8'h70;
	localparam logic [7:0] OP_HW_BUSY_OFF  = 8'h80;
	localparam logic [1:0] ADDR_LAST_BYTE  = 2'h2;
	localparam logic [2:0] LAST_BIT        = 3'h7;

	// ****************************************************************
	// Status byte layout
	// ****************************************************************
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_WLF_BIT  = 1;
	localparam int ST_HWB_BIT  = 5;
	localparam int ST_INC_BIT  = 6;

	// ****************************************************************
	// Register bus map
	// ****************************************************************
	localparam int PADDR_W = 12;
	localparam logic [PADDR_W-1:0] REG_PROT_OFS   = 12'h000;
	localparam logic [PADDR_W-1:0] REG_STATUS_OFS = 12'h004;
	localparam logic [NBLK-1:0]    PROT_RST       = 8'h00;

	// ****************************************************************
	// Self-timed operation durations
	// ****************************************************************
	localparam int CLK_MHZ               = 250;
	localparam int BYTE_PROGRAM_TIME_NS  = 9000;
	localparam int SECTOR_ERASE_TIME_MS  = 60;
	localparam int BLOCK_ERASE_TIME_MS   = 1000;
	localparam int CHIP_ERASE_TIME_MS    = 4000;
	localparam int BYTE_PROGRAM_CYC      = (BYTE_PROGRAM_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int SECTOR_ERASE_CYC      = SECTOR_ERASE_TIME_MS * CLK_MHZ * 1000;
	localparam int BLOCK_ERASE_CYC       = BLOCK_ERASE_TIME_MS * CLK_MHZ * 1000;
	localparam int CHIP_ERASE_CYC        = CHIP_ERASE_TIME_MS * CLK_MHZ * 1000;

	typedef enum logic [2:0] {
		PH_CMD,
		PH_ADDR,
		PH_DUMMY,
		PH_WDATA,
		PH_RDOUT,
		PH_STOUT,
		PH_SKIP
	} sfe_phase_t;

endpackage

/* File: tb/sfe_cmd_engine_assertions.sv */
// Port-level concurrent checks for the serial flash command engine
`timescale 1ns/1ps

module sfe_cmd_engine_assertions
	import sfe_pkg::*;
(
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic [31:0]        pwdata,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic               link_sel_n,
	input wire logic               link_clk,
	input wire logic               link_din,
	input wire logic               link_dout,
	input wire logic               link_dout_oe_n
);
	// ****************************************************************
	// Helper state
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	wire  st_rd = psel && penable && pready && !pwrite && paddr == REG_STATUS_OFS;
	wire  pr_rd = psel && penable && pready && !pwrite && paddr == REG_PROT_OFS;
	logic busy_q;
	logic rise_q;
	logic sel_q;

	// A busy flag may only appear after a select rise seen since the last busy report
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			busy_q <= 1'b0;
			rise_q <= 1'b0;
			sel_q  <= 1'b1;
		end
		else
		begin
			busy_q <= st_rd ? prdata[0] : busy_q;
			rise_q <= (link_sel_n && !sel_q) || (rise_q && !(st_rd && prdata[0]));
			sel_q  <= link_sel_n;
		end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_ready_one_cycle: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not a single pulse after setup");
	a_err_unmapped: assert property (pready |->
		pslverr == (paddr != REG_PROT_OFS && paddr != REG_STATUS_OFS))
		else $error("pslverr does not match address decode");
	a_status_layout: assert property (st_rd |-> prdata[31:7] == 25'h0 && prdata[4:2] == 3'h0)
		else $error("status read has bits outside its layout");
	a_prot_width: assert property (pr_rd |-> prdata[31:8] == 24'h0)
		else $error("protection read has bits above block count");
	a_busy_after_rise: assert property (st_rd && prdata[0] && !busy_q |-> rise_q)
		else $error("busy began without a select rise");
	a_oe_needs_sel: assert property ($fell(link_dout_oe_n) |-> $past(!link_sel_n, 2))
		else $error("data out driven without select low");
	a_oe_released: assert property (link_sel_n [*6] |-> link_dout_oe_n)
		else $error("data out still driven after select rise");
	a_dout_on_fall: assert property (!link_dout_oe_n && $past(!link_dout_oe_n) &&
		$changed(link_dout) |-> !link_clk)
		else $error("data out changed while link clock high");
endmodule // sfe_cmd_engine_assertions

bind sfe_cmd_engine sfe_cmd_engine_assertions u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .link_sel_n(link_sel_n),
	.link_clk(link_clk), .link_din(link_din), .link_dout(link_dout),
	.link_dout_oe_n(link_dout_oe_n));

/* File: tb/sfe_cmd_engine_tb.sv */
// Self-checking bench of the serial flash command engine
`timescale 1ns/1ps

module sfe_cmd_engine_tb;
	import sfe_pkg::*;
	// ****************************************************************
	// Signals, reference array and helpers
	// ****************************************************************
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [PADDR_W-1:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r, rnd_q = 32'ha7de;
	logic pready, pslverr, link_sel_n, link_clk, link_din, link_dout, link_dout_oe_n, e;
	logic [7:0] mem [int];
	logic [7:0] ops [6] = '{8'h20, 8'hd8, 8'h02, 8'had, 8'h60, 8'hc7};
	logic [23:0] a;
	int bad_count = 0, checked = 0, j, k, base;

	always #2 pclk = ~pclk;

	// Short erase times keep the run small; the erase walk still dominates
	sfe_cmd_engine #(.SECTOR_ERASE_CYC(100), .BLOCK_ERASE_CYC(100), .CHIP_ERASE_CYC(100)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_sel_n(link_sel_n), .link_clk(link_clk), .link_din(link_din),
		.link_dout(link_dout), .link_dout_oe_n(link_dout_oe_n));
	sfe_host_model host (.pclk(pclk), .link_sel_n(link_sel_n), .link_clk(link_clk),
		.link_din(link_din), .link_dout(link_dout), .link_dout_oe_n(link_dout_oe_n));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task end_sim;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask

	task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= ad;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 50)
			begin
				bad_count++;
				end_sim();
			end
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [11:0] ad, input logic [31:0] x, input logic xe);
		apb(1'b0, ad, 32'h0);
		chk("prdata", r, x);
		chk("pslverr", {31'h0, e}, {31'h0, xe});
	endtask

	task idle;
		for (int n = 0; n < 30000; n++)
		begin
			apb(1'b0, REG_STATUS_OFS, 32'h0);
			if (r[0] === 1'b0)
				return;
		end
		chk("busy_wait", 32'h1, 32'h0);
		end_sim();
	endtask

	task tx(input logic [7:0] op, input int na, input logic [23:0] ad, input int nd,
		input logic [15:0] d, input int nrx);
		host.tx_q = {op};
		for (int q = 0; q < 3 * na; q++) host.tx_q.push_back(ad[23 - 8 * q -: 8]);
		for (int q = nd; q > 0; q--) host.tx_q.push_back(d[8 * q - 1 -: 8]);
		host.frame(nrx);
	endtask

	task op1(input logic [7:0] op);
		tx(op, 0, 24'h000000, 0, 16'h0000, 0);
	endtask

	task rxq(input int ad, input logic [7:0] x);
		for (int q = 0; q < host.rx_q.size(); q++)
			chk("link_dout", {24'h0, host.rx_q[q]}, {24'h0, ad < 0 ? x : mem[(ad + q) & 32'h7ffff]});
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		rd(REG_PROT_OFS, 32'h0, 1'b0);
		rd(REG_STATUS_OFS, 32'h0, 1'b0);
		apb(1'b1, REG_STATUS_OFS, 32'hff);
		rd(REG_STATUS_OFS, 32'h0, 1'b0);
		rd(12'h008, 32'h0, 1'b1);
		tx(8'h02, 1, 24'h07f100, 1, 16'h0000, 0);
		rd(REG_STATUS_OFS, 32'h0, 1'b0);
		op1(8'h06);
		rd(REG_STATUS_OFS, 32'h2, 1'b0);
		op1(8'h04);
		rd(REG_STATUS_OFS, 32'h0, 1'b0);
		$display("test registers and latch done");
		for (j = 0; j < 2; j++)
		begin
			rnd_q = lfsr(rnd_q);
			base = j ? 0 : 32'h7f000;
			a = {rnd_q[23:19], base[18:12], rnd_q[11:0]};
			op1(8'h06);
			tx(8'h20, 1, a, 0, 16'h0000, 0);
			tx(8'h05, 0, 24'h000000, 0, 16'h0000, 2);
			rxq(-1, 8'h03);
			idle();
			for (k = 0; k < 4096; k++) mem[base + k] = ERASED_BYTE;
		end
		$display("test sector erase done");
		rnd_q = lfsr(rnd_q);
		op1(8'h06);
		tx(8'h02, 1, 24'h07f100, 1, rnd_q[15:0], 0);
		rd(REG_STATUS_OFS, 32'h3, 1'b0);
		idle();
		mem[32'h7f100] = rnd_q[7:0];
		tx(8'h0b, 1, 24'h07f100, 1, 16'h0000, 2);
		rxq(32'h7f100, 8'h00);
		$display("test byte program done");
		op1(8'h70);
		rd(REG_STATUS_OFS, 32'h20, 1'b0);
		op1(8'h06);
		rnd_q = lfsr(rnd_q);
		tx(8'had, 1, 24'h07fffd, 2, rnd_q[15:0], 0);
		host.probe();
		chk("hw_busy", {30'h0, host.oe_s, host.do_s}, 32'h0);
		idle();
		rd(REG_STATUS_OFS, 32'h62, 1'b0);
		tx(8'h02, 1, 24'h07f200, 1, 16'h0000, 0);
		rd(REG_STATUS_OFS, 32'h62, 1'b0);
		host.probe();
		chk("hw_ready", {30'h0, host.oe_s, host.do_s}, 32'h1);
		tx(8'had, 0, 24'h000000, 2, rnd_q[31:16], 0);
		idle();
		rd(REG_STATUS_OFS, 32'h20, 1'b0);
		mem[32'h7fffc] = rnd_q[15:8];
		mem[32'h7fffd] = rnd_q[7:0];
		mem[32'h7fffe] = rnd_q[31:24];
		mem[32'h7ffff] = rnd_q[23:16];
		host.probe();
		chk("hw_release", {31'h0, host.oe_s}, 32'h1);
		op1(8'h04);
		op1(8'h80);
		rd(REG_STATUS_OFS, 32'h0, 1'b0);
		tx(8'h03, 1, 24'h07fffc, 0, 16'h0000, 6);
		rxq(32'h7fffc, 8'h00);
		$display("test pair program and read done");
		apb(1'b1, REG_PROT_OFS, 32'h80);
		rd(REG_PROT_OFS, 32'h80, 1'b0);
		for (j = 0; j < 6; j++)
		begin
			rnd_q = lfsr(rnd_q);
			op1(8'h06);
			tx(ops[j], j < 4, {5'h00, 7'h7f, rnd_q[11:0]}, j == 2 ? 1 : j == 3 ? 2 : 0,
				16'hffff, 0);
			apb(1'b0, REG_STATUS_OFS, 32'h0);
			chk("busy", {31'h0, r[0]}, 32'h0);
		end
		op1(8'h04);
		$display("test protection done");
		end_sim();
	end
endmodule // sfe_cmd_engine_tb

/* File: tb/sfe_host_model.sv */
// Host serial controller model: frames commands and clocks data both ways
`timescale 1ns/1ps

module sfe_host_model
(
	input  wire logic pclk,
	output logic      link_sel_n,
	output logic      link_clk,
	output logic      link_din,
	input  wire logic link_dout,
	input  wire logic link_dout_oe_n
);
	// ****************************************************************
	// Frame engine
	// ****************************************************************
	logic [7:0] tx_q [$];
	logic [7:0] rx_q [$];
	logic       oe_s;
	logic       do_s;

	initial
	begin
		link_sel_n = 1'b1;
		link_clk   = 1'b0;
		link_din   = 1'b0;
	end

	// 16 pclk per bit gives 64 ns, well inside both read limits
	task bit_io(input logic v, output logic o);
		link_din <= v;
		repeat (8) @(posedge pclk);
		link_clk <= 1'b1;
		repeat (8) @(posedge pclk);
		o = (link_dout_oe_n === 1'b0) ? link_dout : 1'bx;
		link_clk <= 1'b0;
	endtask

	task frame(input int nrx);
		logic [7:0] b;
		logic       o;
		rx_q = {};
		@(posedge pclk);
		link_sel_n <= 1'b0;
		while (tx_q.size() > 0)
		begin
			b = tx_q.pop_front();
			for (int k = 7; k >= 0; k--) bit_io(b[k], o);
		end
		repeat (nrx)
		begin
			// Input line toggles while the device talks, so a stale level never looks valid
			for (int k = 7; k >= 0; k--)
			begin
				bit_io(~link_din, o);
				b[k] = o;
			end
			rx_q.push_back(b);
		end
		repeat (8) @(posedge pclk);
		link_sel_n <= 1'b1;
		link_din   <= ~link_din;
		repeat (12) @(posedge pclk);
	endtask

	// Short select pulse with no clocks, to look at the busy level
	task probe;
		@(posedge pclk);
		link_sel_n <= 1'b0;
		repeat (6) @(posedge pclk);
		oe_s = link_dout_oe_n;
		do_s = link_dout;
		link_sel_n <= 1'b1;
		repeat (12) @(posedge pclk);
	endtask
endmodule // sfe_host_model
